// [inc/bsi_map.vh]
`ifndef BSI_MAP_VH
`define BSI_MAP_VH
// instruction codes
`define BSI_OP_EXT_TEST 8'h00
`define BSI_OP_IDENT 8'h21
`define BSI_OP_SAMPLE 8'h05
`define BSI_OP_CLAMP 8'h07
`define BSI_OP_HIGHZ 8'h03
`define BSI_OP_BYPASS 8'hff
// register sizes, capture pattern and tms reset hold count
`define BSI_IR_W 8
`define BSI_ID_W 32
`define BSI_BSR_W 113
`define BSI_IR_CAPT 2'h1
`define BSI_RESET_HOLD 3'h5
// identification word, arbitrary value
`define BSI_ID_VALUE 32'h1234_5679
`endif

// [rtl/bsi_pin_sync.v]
`timescale 1ns/10ps
module bsi_pin_sync (
   mclk,
   resetn,
   pin_in,
   pin_out
);
   input wire mclk;
   input wire resetn;
   input wire [3:0] pin_in;
   output reg [3:0] pin_out;
   reg [3:0] meta_r;
   // two stages against metastability of the test pins
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 4'h0;
         pin_out <= 4'h0;
      end else begin
         meta_r <= pin_in;
         pin_out <= meta_r;
      end
   end
endmodule

// [rtl/bsi_tap.v]
`timescale 1ns/10ps
// Behaviour
// - instruction register is eight bits; only listed codes implemented
// - state machine and serial access follow the standard scan convention
// - in shift-ir the instruction register sits between tdi and tdo
// - shifted instruction takes effect only at update-ir
// - ext-test 00 captures io ring, selects boundary register
// - ext-test at update-ir enables drivers with preloaded values
// - ident 21 captures 32-bit id code, shifts out in shift-dr
// - ident loaded at power-up and in test-logic-reset
// - sample 05 captures input and bidirectional balls, selects boundary
// - shift-dr after capture shifts the boundary register out
// - clamp 07 selects bypass, outputs driven from boundary register
// - high-z 03 floats all outputs and selects bypass
// - bypass ff selects the single-bit bypass register
// - test logic never disturbs normal memory operation
// - capture-ir loads binary 01 into the two low ir bits
// - inputs sampled on tck rise, tdo updated on tck fall
// - five tms-high rising edges reach test-logic-reset
// - boundary register 113 bits, msb at tdi, lsb at tdo
`include "bsi_map.vh"
module bsi_tap (
   mclk,
   resetn,
   tck,
   tms,
   tdi,
   trst_pin,
   ring_in,
   core_out,
   core_oe,
   tdo_o,
   tdo_oe,
   ball_out,
   ball_oe,
   test_mode,
   instr
);
   input wire mclk;
   input wire resetn;
   input wire tck;
   input wire tms;
   input wire tdi;
   input wire trst_pin;
   input wire [112:0] ring_in;
   input wire [112:0] core_out;
   input wire [112:0] core_oe;
   output reg tdo_o;
   output reg tdo_oe;
   output reg [112:0] ball_out;
   output reg [112:0] ball_oe;
   output reg test_mode;
   output reg [7:0] instr;

   localparam [15:0] S_TLR = 16'h0001;
   localparam [15:0] S_RTI = 16'h0002;
   localparam [15:0] S_SDR = 16'h0004;
   localparam [15:0] S_CDR = 16'h0008;
   localparam [15:0] S_SHDR = 16'h0010;
   localparam [15:0] S_E1DR = 16'h0020;
   localparam [15:0] S_PDR = 16'h0040;
   localparam [15:0] S_E2DR = 16'h0080;
   localparam [15:0] S_UDR = 16'h0100;
   localparam [15:0] S_SIR = 16'h0200;
   localparam [15:0] S_CIR = 16'h0400;
   localparam [15:0] S_SHIR = 16'h0800;
   localparam [15:0] S_E1IR = 16'h1000;
   localparam [15:0] S_PIR = 16'h2000;
   localparam [15:0] S_E2IR = 16'h4000;
   localparam [15:0] S_UIR = 16'h8000;

   localparam [1:0] SEL_BYP = 2'h0;
   localparam [1:0] SEL_ID = 2'h1;
   localparam [1:0] SEL_BSR = 2'h2;

   function [1:0] dr_sel;
      input [7:0] op;
      begin
         case (op)
            `BSI_OP_EXT_TEST: dr_sel = SEL_BSR;
            `BSI_OP_SAMPLE: dr_sel = SEL_BSR;
            `BSI_OP_IDENT: dr_sel = SEL_ID;
            default: dr_sel = SEL_BYP;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   wire [3:0] sync_w;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire trst_s;
   bsi_pin_sync u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .pin_in({trst_pin, tdi, tms, tck}),
      .pin_out(sync_w)
   );
   assign tck_s = sync_w[0];
   assign tms_s = sync_w[1];
   assign tdi_s = sync_w[2];
   assign trst_s = sync_w[3];

   reg tck_d_r;
   reg [1:0] warm_r;
   wire armed;
   wire rise;
   wire fall;
   // edges only trusted once the synchroniser has filled after reset,
   // so a test clock parked high does not fake a rise
   assign armed = (warm_r == 2'h3);
   assign rise = armed & tck_s & ~tck_d_r;
   assign fall = armed & ~tck_s & tck_d_r;

   reg [15:0] st_r;
   reg [15:0] st_nxt;
   reg [7:0] ir_sh_r;
   reg [`BSI_ID_W-1:0] id_sh_r;
   reg [`BSI_BSR_W-1:0] bsr_sh_r;
   reg [`BSI_BSR_W-1:0] bsr_up_r;
   reg byp_r;
   reg [2:0] tms_cnt_r;
   wire [1:0] sel;
   assign sel = dr_sel(instr);
   wire to_tlr;
   // forced or normal path into reset
   assign to_tlr = (tms_s && tms_cnt_r == `BSI_RESET_HOLD - 3'h1) ||
      (st_nxt == S_TLR);

   ////////////////////////////////////////////////////////////////////
   // standard tap transitions
   always @* begin
      case (st_r)
         S_TLR: st_nxt = tms_s ? S_TLR : S_RTI;
         S_RTI: st_nxt = tms_s ? S_SDR : S_RTI;
         S_SDR: st_nxt = tms_s ? S_SIR : S_CDR;
         S_CDR: st_nxt = tms_s ? S_E1DR : S_SHDR;
         S_SHDR: st_nxt = tms_s ? S_E1DR : S_SHDR;
         S_E1DR: st_nxt = tms_s ? S_UDR : S_PDR;
         S_PDR: st_nxt = tms_s ? S_E2DR : S_PDR;
         S_E2DR: st_nxt = tms_s ? S_UDR : S_SHDR;
         S_UDR: st_nxt = tms_s ? S_SDR : S_RTI;
         S_SIR: st_nxt = tms_s ? S_TLR : S_CIR;
         S_CIR: st_nxt = tms_s ? S_E1IR : S_SHIR;
         S_SHIR: st_nxt = tms_s ? S_E1IR : S_SHIR;
         S_E1IR: st_nxt = tms_s ? S_UIR : S_PIR;
         S_PIR: st_nxt = tms_s ? S_E2IR : S_PIR;
         S_E2IR: st_nxt = tms_s ? S_UIR : S_SHIR;
         S_UIR: st_nxt = tms_s ? S_SDR : S_RTI;
         default: st_nxt = S_TLR;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // power-up state and ident load
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tck_d_r <= 1'b0;
         warm_r <= 2'h0;
         st_r <= S_TLR;
         tms_cnt_r <= 3'h0;
         instr <= `BSI_OP_IDENT;
         ir_sh_r <= 8'h00;
         id_sh_r <= 32'h0000_0000;
         bsr_sh_r <= {`BSI_BSR_W{1'b0}};
         bsr_up_r <= {`BSI_BSR_W{1'b0}};
         byp_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
         if (!armed) begin
            warm_r <= warm_r + 2'h1;
         end
         // optional reset pin also returns the tap to idle test logic
         if (trst_s) begin
            st_r <= S_TLR;
            instr <= `BSI_OP_IDENT;
            tms_cnt_r <= 3'h0;
         end else if (rise) begin
            if (to_tlr) begin
               st_r <= S_TLR;
            end else begin
               st_r <= st_nxt;
            end
            if (tms_s && tms_cnt_r != `BSI_RESET_HOLD) begin
               tms_cnt_r <= tms_cnt_r + 3'h1;
            end else if (!tms_s) begin
               tms_cnt_r <= 3'h0;
            end
            // ident loaded on reset entry
            // test logic goes inactive at once, not one tck later
            if (to_tlr) begin
               instr <= `BSI_OP_IDENT;
            end
            if (st_r == S_CIR) begin
               ir_sh_r <= {6'h00, `BSI_IR_CAPT};
            end
            if (st_r == S_SHIR) begin
               ir_sh_r <= {tdi_s, ir_sh_r[7:1]};
            end
            if (st_r == S_UIR && !to_tlr) begin
               instr <= ir_sh_r;
            end
            if (st_r == S_CDR) begin
               id_sh_r <= `BSI_ID_VALUE;
               if (sel == SEL_BSR) begin
                  bsr_sh_r <= ring_in;
               end
               byp_r <= 1'b0;
            end
            if (st_r == S_SHDR) begin
               // msb from tdi, lsb to tdo
               case (sel)
                  SEL_BSR: bsr_sh_r <= {tdi_s, bsr_sh_r[112:1]};
                  SEL_ID: id_sh_r <= {tdi_s, id_sh_r[31:1]};
                  default: byp_r <= tdi_s;
               endcase
            end
            // preload reaches the update stage here
            if (st_r == S_UDR && sel == SEL_BSR) begin
               bsr_up_r <= bsr_sh_r;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // tdo changes on the falling edge
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tdo_o <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (fall) begin
         tdo_oe <= (st_r == S_SHIR) || (st_r == S_SHDR);
         if (st_r == S_SHIR) begin
            tdo_o <= ir_sh_r[0];
         end else begin
            case (sel)
               SEL_BSR: tdo_o <= bsr_sh_r[0];
               SEL_ID: tdo_o <= id_sh_r[0];
               default: tdo_o <= byp_r;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ball drive; test modes follow the applied instruction only
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ball_out <= {`BSI_BSR_W{1'b0}};
         ball_oe <= {`BSI_BSR_W{1'b0}};
         test_mode <= 1'b0;
      end else begin
         case (instr)
            `BSI_OP_EXT_TEST, `BSI_OP_CLAMP: begin
               ball_out <= bsr_up_r;
               ball_oe <= {`BSI_BSR_W{1'b1}};
               test_mode <= 1'b1;
            end
            `BSI_OP_HIGHZ: begin
               ball_out <= core_out;
               ball_oe <= {`BSI_BSR_W{1'b0}};
               test_mode <= 1'b1;
            end
            default: begin
               ball_out <= core_out;
               ball_oe <= core_oe;
               test_mode <= 1'b0;
            end
         endcase
      end
   end
endmodule

// [tb/bsi_tap_sva.sv]
`timescale 1ns/10ps
`include "bsi_map.vh"
module bsi_tap_sva (
   input wire mclk, resetn, tck, trst_pin, tdo_o, tdo_oe, test_mode,
   input wire [112:0] core_out, core_oe, ball_out, ball_oe,
   input wire [7:0] instr
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   wire tm = instr == `BSI_OP_EXT_TEST || instr == `BSI_OP_CLAMP ||
      instr == `BSI_OP_HIGHZ;
   AST_RST_IDENT: assert property ($rose(resetn) |-> instr == 8'h21)
      else $error("instr not ident after reset");
   // tck pin is seen late through the synchroniser, so look 2 back
   AST_TDO_FALL: assert property (!$stable(tdo_o) |-> !$past(tck, 2))
      else $error("tdo moved with tck high");
   AST_OE_FALL: assert property (!$stable(tdo_oe) |-> !$past(tck, 2))
      else $error("tdo enable moved with tck high");
   AST_HIGHZ: assert property (instr == 8'h03 |=> ball_oe == '0)
      else $error("ball driven in high-z");
   AST_EXT_ON: assert property (instr == 8'h00 |=> &ball_oe)
      else $error("drivers off in ext-test");
   AST_FUNC: assert property (!tm |=> ball_out == $past(core_out)
      && ball_oe == $past(core_oe))
      else $error("functional drive lost");
   AST_TMODE: assert property ($stable(instr) |-> test_mode == tm)
      else $error("test mode wrong");
   AST_TRST: assert property (trst_pin [*3] |-> ##[0:4] instr == 8'h21)
      else $error("trst did not reset instr");
   C_HZ: cover property (instr == 8'h03);
   C_EXT: cover property (instr == 8'h00);
   C_SHIFT: cover property ($rose(tdo_oe));
endmodule
bind bsi_tap bsi_tap_sva u_sva (
   .mclk(mclk),
   .resetn(resetn),
   .tck(tck),
   .trst_pin(trst_pin),
   .tdo_o(tdo_o),
   .tdo_oe(tdo_oe),
   .test_mode(test_mode),
   .core_out(core_out),
   .core_oe(core_oe),
   .ball_out(ball_out),
   .ball_oe(ball_oe),
   .instr(instr)
);

// [tb/bsi_ctl_model.sv]
`timescale 1ns/10ps
module bsi_ctl_model (
   input wire mclk,
   input wire tdo_o,
   output logic tck = 1'b0,
   output logic tms = 1'b1,
   output logic tdi = 1'b1
);
   // change at fall, hold past rise
   task automatic pulse(input logic m, input logic d, output logic o);
      @(posedge mclk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge mclk);
      tck <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 o = tdo_o;
   endtask
   task automatic tap_reset();
      logic o;
      repeat (5) pulse(1'b1, 1'b1, o);
      pulse(1'b0, 1'b1, o);
   endtask
   // header from idle, then shift; stops in exit1
   task automatic shift(input logic [3:0] h, input int nh, input int n,
         input logic [112:0] d, output logic [112:0] q);
      logic o;
      q = '0;
      for (int i = 0; i < nh; i++) pulse(h[i], 1'b0, o);
      for (int k = 0; k < n; k++) begin
         pulse(k == n - 1, d[k], o);
         q[k] = o;
      end
   endtask
   // update then idle; tdi toggled at each step, so it ends at its entry value
   task automatic leave();
      logic o;
      pulse(1'b1, ~tdi, o);
      pulse(1'b0, ~tdi, o);
   endtask
endmodule

// [tb/test_boundary_scan_instruction_decode.sv]
`timescale 1ns/10ps
`include "bsi_map.vh"
module test_boundary_scan_instruction_decode;
   localparam logic [112:0] PAT = {1'b1, 112'h0f1e2d3c4b5a69788796a5b4c3d2};
   localparam logic [112:0] RING = {1'b0, 112'h5a5ac3c30ff096691234abcde0e1};
   localparam logic [7:0] OPS [7] = '{`BSI_OP_IDENT, `BSI_OP_SAMPLE,
      `BSI_OP_EXT_TEST, `BSI_OP_CLAMP, `BSI_OP_HIGHZ, `BSI_OP_BYPASS, 8'h5a};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic trst_pin = 1'b0;
   logic [112:0] ring_in = RING;
   logic [112:0] core_out = ~RING;
   logic [112:0] core_oe = {57'h1ffffffffffffff, 56'h0};
   wire tck, tms, tdi, tdo_o, tdo_oe, test_mode;
   wire [112:0] ball_out, ball_oe;
   wire [7:0] instr;
   int n_errors = 0;
   int checked = 0;
   always #50 mclk = ~mclk;
   bsi_tap dut (
      .mclk(mclk),
      .resetn(resetn),
      .tck(tck),
      .tms(tms),
      .tdi(tdi),
      .trst_pin(trst_pin),
      .ring_in(ring_in),
      .core_out(core_out),
      .core_oe(core_oe),
      .tdo_o(tdo_o),
      .tdo_oe(tdo_oe),
      .ball_out(ball_out),
      .ball_oe(ball_oe),
      .test_mode(test_mode),
      .instr(instr)
   );
   bsi_ctl_model u_ctl (
      .mclk(mclk),
      .tdo_o(tdo_o),
      .tck(tck),
      .tms(tms),
      .tdi(tdi)
   );
   task automatic report_and_stop();
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [112:0] e, g);
      checked++;
      if (e !== g) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic load_ir(input logic [7:0] c);
      logic [112:0] q;
      logic [7:0] old;
      old = instr;
      u_ctl.shift(4'b0011, 4, 8, {105'h0, c}, q);
      chk("ir capture", 113'h1, q);
      chk("instr held", old, instr);
      chk("tdo enable", 1'b1, tdo_oe);
      u_ctl.leave();
      chk("instr", c, instr);
   endtask
   task automatic t_power_up();
      chk("instr", `BSI_OP_IDENT, instr);
      chk("tdo enable", 1'b0, tdo_oe);
      chk("ball", core_out, ball_out);
      u_ctl.tap_reset();
   endtask
   task automatic t_codes();
      logic [7:0] c;
      logic [112:0] q;
      logic tm;
      for (int i = 0; i < 7; i++) begin
         c = OPS[i];
         load_ir(c);
         tm = c == 8'h00 || c == 8'h07 || c == 8'h03;
         chk("test mode", tm, test_mode);
         if (c == `BSI_OP_HIGHZ)
            chk("ball oe", '0, ball_oe);
         else if (tm)
            chk("preload", PAT, ball_out);
         else
            chk("ball", core_out, ball_out);
         u_ctl.shift(4'b0001, 3, 113, PAT, q);
         u_ctl.leave();
         if (c == `BSI_OP_IDENT)
            chk("id", `BSI_ID_VALUE, q[31:0]);
         else if (c == 8'h05 || c == 8'h00)
            chk("ring", RING, q);
         else
            chk("bypass", {PAT[111:0], 1'b0}, q);
      end
   endtask
   task automatic t_resets();
      u_ctl.tap_reset();
      chk("tap reset", `BSI_OP_IDENT, instr);
      load_ir(`BSI_OP_BYPASS);
      @(posedge mclk);
      trst_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      trst_pin <= 1'b0;
      #1;
      chk("trst", `BSI_OP_IDENT, instr);
      u_ctl.tap_reset();
      load_ir(`BSI_OP_BYPASS);
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      chk("power up", `BSI_OP_IDENT, instr);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      t_power_up();
      t_codes();
      t_resets();
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      report_and_stop();
   end
endmodule
